// File: logic/accr_pkg.sv
`default_nettype none
package accr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] ACCR_IDX_CH1_GAIN_HIGH = 8'h11;
  localparam logic [7:0] ACCR_IDX_CH1_GAIN_LOW = 8'h12;
  localparam logic [7:0] ACCR_IDX_CH2_CONFIG = 8'h13;
  localparam int ACCR_ADDR_W = 12;
  localparam logic [ACCR_ADDR_W-1:0] ACCR_ADDR_CH1_GAIN_HIGH = 12'h044;
  localparam logic [ACCR_ADDR_W-1:0] ACCR_ADDR_CH1_GAIN_LOW = 12'h048;
  localparam logic [ACCR_ADDR_W-1:0] ACCR_ADDR_CH2_CONFIG = 12'h04c;
  // Reset values
  localparam logic [15:0] ACCR_RST_GAIN_HIGH = 16'h8000;
  localparam logic [7:0] ACCR_RST_GAIN_LOW = 8'h00;
  localparam logic [9:0] ACCR_RST_PHASE = 10'h000;
  localparam logic ACCR_RST_DC_OFF = 1'b0;
  // Field positions
  localparam int ACCR_GLOW_LSB = 8;
  localparam int ACCR_PHASE_LSB = 6;
  localparam int ACCR_DCOFF_BIT = 2;
  localparam int ACCR_MUX_LSB = 0;
  // Input selector encodings
  typedef enum logic [1:0] {
    ACCR_IN_PINS = 2'h0,
    ACCR_IN_SHORT = 2'h1,
    ACCR_IN_TEST_POS = 2'h2,
    ACCR_IN_TEST_NEG = 2'h3
  } accr_input_t;
endpackage
`default_nettype wire

// File: logic/accr_regs.sv
// How it works
// - Bits 15:8 of the gain trim low register hold gain bits 7:0, writable, reset zero.
// - The gain trim high register supplies gain bits 23:8 and resets to 8000h.
// - Bits 7:0 of the gain trim low register are read-only and always read zero.
// - Bits 15:6 of channel 2 config hold a signed 10-bit phase delay, reset zero.
// - Bit 2 of channel 2 config set disables DC blocking for channel 2 only.
// - Bits 1:0 of channel 2 config choose pins, shorted, positive or negative test.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module accr_regs
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [accr_pkg::ACCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic global_dc_block_setting,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic [23:0] ch1_gain_trim,
  output logic [9:0] ch2_phase_delay,
  output logic ch2_dc_block_off,
  output logic ch2_dc_block_on,
  output logic [1:0] ch2_input_select
);
  import accr_pkg::*;

  typedef struct packed {
    logic [15:0] gain_high;
    logic [7:0] gain_low;
    logic [9:0] phase;
    logic dc_off;
    logic [1:0] in_sel;
    logic dc_on;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } accr_state_t;

  accr_state_t st;
  accr_state_t next_st;
  logic setup;
  logic wr;
  logic hit_high;
  logic hit_low;
  logic hit_cfg;
  logic [15:0] rd_word;

  // No wait states: pready rises in the access phase right after setup
  assign setup = psel && !penable;
  // Writes commit only at the access edge, where the master sees pready
  assign wr = psel && penable && pwrite && st.ready;
  assign hit_high = (paddr == ACCR_ADDR_CH1_GAIN_HIGH);
  assign hit_low = (paddr == ACCR_ADDR_CH1_GAIN_LOW);
  assign hit_cfg = (paddr == ACCR_ADDR_CH2_CONFIG);

  // Read mux; reserved bits come back as zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit_high) begin
      rd_word = st.gain_high;
    end else if (hit_low) begin
      rd_word = {st.gain_low, 8'h00};
    end else if (hit_cfg) begin
      rd_word = {st.phase, 3'h0, st.dc_off, st.in_sel};
    end
  end

  // Next state; read data is caught at setup so it stands with pready
  always_comb begin
    next_st = st;
    next_st.ready = setup;
    next_st.err = setup && !(hit_high || hit_low || hit_cfg);
    if (setup && !pwrite) begin
      next_st.rdata = {16'h0000, rd_word};
    end else if (setup) begin
      next_st.rdata = 32'h0000_0000;
    end
    if (wr && hit_high) begin
      if (pstrb[0]) begin
        next_st.gain_high[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_st.gain_high[15:8] = pwdata[15:8];
      end
    end
    if (wr && hit_low && pstrb[1]) begin
      next_st.gain_low = pwdata[ACCR_GLOW_LSB +: 8];
    end
    if (wr && hit_cfg) begin
      // Bits 5:3 are simply never stored
      if (pstrb[0]) begin
        next_st.in_sel = pwdata[ACCR_MUX_LSB +: 2];
        next_st.dc_off = pwdata[ACCR_DCOFF_BIT];
        next_st.phase[1:0] = pwdata[ACCR_PHASE_LSB +: 2];
      end
      if (pstrb[1]) begin
        next_st.phase[9:2] = pwdata[ACCR_PHASE_LSB+2 +: 8];
      end
    end
    // Channel override beats the global setting
    next_st.dc_on = global_dc_block_setting && !next_st.dc_off;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.gain_high <= ACCR_RST_GAIN_HIGH;
      st.gain_low <= ACCR_RST_GAIN_LOW;
      st.phase <= ACCR_RST_PHASE;
      st.dc_off <= ACCR_RST_DC_OFF;
      st.in_sel <= ACCR_IN_PINS;
      st.dc_on <= 1'b0;
      st.ready <= 1'b0;
      st.err <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign pready = st.ready;
  assign pslverr = st.err;
  assign prdata = st.rdata;
  assign ch1_gain_trim = {st.gain_high, st.gain_low};
  assign ch2_phase_delay = st.phase;
  assign ch2_dc_block_off = st.dc_off;
  assign ch2_dc_block_on = st.dc_on;
  assign ch2_input_select = st.in_sel;

  property p_gain_low_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_low && pstrb[1]) |=> (ch1_gain_trim[7:0] == $past(pwdata[15:8]));
  endproperty
  a_gain_low_write: assert property (p_gain_low_write)
    else $error("gain low byte not stored");

  property p_gain_high_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_high && pstrb[1:0] == 2'h3) |=> (ch1_gain_trim[23:8] == $past(pwdata[15:0]));
  endproperty
  a_gain_high_write: assert property (p_gain_high_write)
    else $error("gain high word not stored");

  property p_low_reserved;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_low) |=> (prdata[7:0] == 8'h00 && pready);
  endproperty
  a_low_reserved: assert property (p_low_reserved)
    else $error("reserved gain bits read nonzero");

  property p_phase_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg && pstrb[1:0] == 2'h3) |=> (ch2_phase_delay == $past(pwdata[15:6]));
  endproperty
  a_phase_write: assert property (p_phase_write)
    else $error("phase delay not stored");

  property p_dc_override;
    @(posedge pclk) disable iff (!presetn)
      ch2_dc_block_off |-> !ch2_dc_block_on;
  endproperty
  a_dc_override: assert property (p_dc_override)
    else $error("dc block on while overridden");

  property p_dc_global;
    @(posedge pclk) disable iff (!presetn)
      (global_dc_block_setting && !ch2_dc_block_off && !(wr && hit_cfg)) |=> ch2_dc_block_on;
  endproperty
  a_dc_global: assert property (p_dc_global)
    else $error("global dc setting not followed");

  property p_mux_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg && pstrb[0]) |=> (ch2_input_select == $past(pwdata[1:0]));
  endproperty
  a_mux_write: assert property (p_mux_write)
    else $error("input select not stored");

  property p_cfg_reserved;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_cfg) |=> (prdata[5:3] == 3'h0 && prdata[15:6] == ch2_phase_delay);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("config readback wrong");

  // Fields hold unless written, read back as stored, and leave reset clean
  property p_gain_low_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_low && pstrb[1]) |=> $stable(ch1_gain_trim[7:0]);
  endproperty
  a_gain_low_hold: assert property (p_gain_low_hold)
    else $error("gain low byte changed without a write");

  property p_gain_low_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_low) |=> (prdata[15:8] == ch1_gain_trim[7:0]);
  endproperty
  a_gain_low_read: assert property (p_gain_low_read)
    else $error("gain low byte read back wrong");

  property p_reset_gain_low;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (ch1_gain_trim[7:0] == ACCR_RST_GAIN_LOW);
  endproperty
  a_reset_gain_low: assert property (p_reset_gain_low)
    else $error("gain low byte not reset");

  property p_gain_high_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_high) |=> $stable(ch1_gain_trim[23:8]);
  endproperty
  a_gain_high_hold: assert property (p_gain_high_hold)
    else $error("gain high word changed without a write");

  property p_gain_high_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_high) |=> (prdata[15:0] == ch1_gain_trim[23:8]);
  endproperty
  a_gain_high_read: assert property (p_gain_high_read)
    else $error("gain high word read back wrong");

  property p_gain_high_upper_lane;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_high && pstrb[1]) |=> (ch1_gain_trim[23:16] == $past(pwdata[15:8]));
  endproperty
  a_gain_high_upper_lane: assert property (p_gain_high_upper_lane)
    else $error("gain high upper byte not stored");

  property p_gain_high_lower_keep;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_high && !pstrb[0]) |=> $stable(ch1_gain_trim[15:8]);
  endproperty
  a_gain_high_lower_keep: assert property (p_gain_high_lower_keep)
    else $error("gain high lower byte written without strobe");

  property p_reset_gain_high;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (ch1_gain_trim[23:8] == ACCR_RST_GAIN_HIGH);
  endproperty
  a_reset_gain_high: assert property (p_reset_gain_high)
    else $error("gain high word not reset");

  property p_phase_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_cfg) |=> $stable(ch2_phase_delay);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("phase delay changed without a write");

  property p_phase_low_lane;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg && pstrb[0]) |=> (ch2_phase_delay[1:0] == $past(pwdata[7:6]));
  endproperty
  a_phase_low_lane: assert property (p_phase_low_lane)
    else $error("phase delay low bits not stored");

  property p_phase_high_lane;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg && pstrb[1]) |=> (ch2_phase_delay[9:2] == $past(pwdata[15:8]));
  endproperty
  a_phase_high_lane: assert property (p_phase_high_lane)
    else $error("phase delay high bits not stored");

  property p_reset_phase;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (ch2_phase_delay == ACCR_RST_PHASE);
  endproperty
  a_reset_phase: assert property (p_reset_phase)
    else $error("phase delay not reset");

  property p_dc_off_write;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cfg && pstrb[0]) |=> (ch2_dc_block_off == $past(pwdata[2]));
  endproperty
  a_dc_off_write: assert property (p_dc_off_write)
    else $error("dc block override not stored");

  property p_dc_off_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_cfg) |=> $stable(ch2_dc_block_off);
  endproperty
  a_dc_off_hold: assert property (p_dc_off_hold)
    else $error("dc block override changed without a write");

  property p_dc_global_off;
    @(posedge pclk) disable iff (!presetn)
      !global_dc_block_setting |=> !ch2_dc_block_on;
  endproperty
  a_dc_global_off: assert property (p_dc_global_off)
    else $error("dc block on while global setting off");

  property p_dc_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_cfg) |=> (prdata[2] == ch2_dc_block_off);
  endproperty
  a_dc_read: assert property (p_dc_read)
    else $error("dc block override read back wrong");

  property p_reset_dc_off;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (ch2_dc_block_off == ACCR_RST_DC_OFF);
  endproperty
  a_reset_dc_off: assert property (p_reset_dc_off)
    else $error("dc block override not reset");

  property p_mux_hold;
    @(posedge pclk) disable iff (!presetn)
      !(wr && hit_cfg) |=> $stable(ch2_input_select);
  endproperty
  a_mux_hold: assert property (p_mux_hold)
    else $error("input select changed without a write");

  property p_mux_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_cfg) |=> (prdata[1:0] == ch2_input_select);
  endproperty
  a_mux_read: assert property (p_mux_read)
    else $error("input select read back wrong");

  property p_reset_select;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> (ch2_input_select == ACCR_IN_PINS);
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("input select not reset");
endmodule
`default_nettype wire

// File: verif/accr_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module accr_regs_bench;
  import accr_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic global_dc_block_setting = 1'b0, pready, pslverr, ch2_dc_block_off, ch2_dc_block_on;
  logic [ACCR_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [23:0] ch1_gain_trim;
  logic [9:0] ch2_phase_delay;
  logic [1:0] ch2_input_select;
  logic err;
  logic [9:0] ph [4] = '{10'h200, 10'h1ff, 10'h3ff, 10'h001};
  int failures = 0, comparisons = 0, cycles = 0;
  accr_regs u_accr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .global_dc_block_setting, .pready, .pslverr, .prdata, .ch1_gain_trim, .ch2_phase_delay,
    .ch2_dc_block_off, .ch2_dc_block_on, .ch2_input_select);
  // 50 MHz clock
  initial begin
    forever #10 pclk = ~pclk;
  end
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 60 cycles needed
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; pready is read before the edge's own updates land
  task automatic apb(input logic w, input logic [ACCR_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ACCR_ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ACCR_ADDR_CH1_GAIN_HIGH, 32'h00008000);
    chk({31'h0, err}, 32'h0);
    rd_chk(ACCR_ADDR_CH1_GAIN_LOW, 32'h00000000);
    rd_chk(ACCR_ADDR_CH2_CONFIG, 32'h00000000);
    chk({8'h00, ch1_gain_trim}, 32'h00800000);
    chk({19'h0, ch2_phase_delay, ch2_dc_block_off, ch2_input_select}, 32'h0);
    $display("test reset values done");
    // All ones into gain low: reserved byte must stay zero
    apb(1'b1, ACCR_ADDR_CH1_GAIN_LOW, 32'h0000ffff);
    rd_chk(ACCR_ADDR_CH1_GAIN_LOW, 32'h0000ff00);
    chk({8'h00, ch1_gain_trim}, 32'h008000ff);
    apb(1'b1, ACCR_ADDR_CH1_GAIN_HIGH, 32'h00001234);
    // Write lands at the access edge; look one edge later
    @(posedge pclk);
    chk({8'h00, ch1_gain_trim}, 32'h001234ff);
    // Byte strobes: lane 1 alone into gain high, lane 0 alone into gain low
    pstrb <= 4'h2;
    apb(1'b1, ACCR_ADDR_CH1_GAIN_HIGH, 32'h0000abcd);
    pstrb <= 4'h1;
    apb(1'b1, ACCR_ADDR_CH1_GAIN_LOW, 32'h00005500);
    pstrb <= 4'hf;
    rd_chk(ACCR_ADDR_CH1_GAIN_LOW, 32'h0000ff00);
    chk({8'h00, ch1_gain_trim}, 32'h00ab34ff);
    $display("test gain trim done");
    // Every selector code, signed phase extremes, override against global
    for (int i = 0; i < 4; i++) begin
      global_dc_block_setting <= i[1];
      apb(1'b1, ACCR_ADDR_CH2_CONFIG, {16'h0, ph[i], 3'b111, i[0], i[1:0]});
      rd_chk(ACCR_ADDR_CH2_CONFIG, {16'h0, ph[i], 3'b000, i[0], i[1:0]});
      chk({22'h0, ch2_phase_delay}, {22'h0, ph[i]});
      chk({31'h0, ch2_dc_block_on}, {31'h0, i[1] & ~i[0]});
      chk({31'h0, ch2_dc_block_off}, {31'h0, i[0]});
      chk({30'h0, ch2_input_select}, {30'h0, i[1:0]});
    end
    $display("test channel 2 config done");
    // Unmapped address is refused
    rd_chk(12'h050, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test unmapped done");
    finish_test();
  end
endmodule
`default_nettype wire
